// ===== rtl/gcg_gate_logic.sv
// gate source, toggle, single pulse and counter event logic
`timescale 1ns/100ps
module gcg_gate_logic #(
    parameter int WDT_W = 8
) (
    input  wire logic                     CORE_CLK_I,
    input  wire logic                     RESETN_I,
    input  wire logic                     GATE_INPUT_PIN_I,
    input  wire logic [1:0]               GATE_SOURCE_SELECT_I,
    input  wire logic                     GATE_POLARITY_I,
    input  wire logic                     GATE_COUNT_ENABLE_I,
    input  wire logic                     COUNTER_RUN_I,
    input  wire logic                     GATE_TOGGLE_ENABLE_I,
    input  wire logic                     GATE_SINGLE_PULSE_ENABLE_I,
    input  wire logic                     GATE_ACQUIRE_GO_SET_I,
    input  wire logic                     GATE_EVENT_IRQ_ENABLE_I,
    input  wire logic                     GATE_EVENT_FLAG_CLR_I,
    input  wire logic                     OVERFLOW_IRQ_ENABLE_I,
    input  wire logic                     OVERFLOW_FLAG_CLR_I,
    input  wire logic                     PERIPHERAL_IRQ_ENABLE_I,
    input  wire logic                     GLOBAL_IRQ_ENABLE_I,
    input  wire logic [1:0]               CLOCK_SOURCE_SELECT_I,
    input  wire logic                     SYNC_BYPASS_I,
    input  wire logic                     INSTR_TICK_I,
    input  wire logic                     EXT_CLK_I,
    input  wire logic                     SLEEP_I,
    input  wire logic                     T8_TICK_I,
    input  wire logic                     PM_TICK_I,
    input  wire logic [gcg_pkg::T8_W-1:0] PERIOD_MATCH_VALUE_I,
    input  wire logic                     WATCHDOG_FUSE_ENABLE_I,
    input  wire logic                     WDT_TICK_I,
    input  wire logic                     WATCHDOG_CLEAR_I,
    input  wire logic                     PRESCALER_ASSIGN_I,
    input  wire logic [gcg_pkg::RATE_W-1:0] PRESCALER_RATE_I,
    input  wire logic                     CNT_WR_I,
    input  wire logic [gcg_pkg::CNT_W-1:0] CNT_WR_DATA_I,
    input  wire logic                     SPECIAL_CLEAR_I,
    input  wire logic                     CAPTURE_I,
    input  wire logic [gcg_pkg::CNT_W-1:0] COMPARE_VALUE_I,
    output logic [gcg_pkg::CNT_W-1:0]     COUNTER_PAIR_O,
    output logic [gcg_pkg::CNT_W-1:0]     CAPTURE_PAIR_O,
    output logic                          COMPARE_MATCH_O,
    output logic                          GATE_ACQUIRE_GO_O,
    output logic                          GATE_LEVEL_STATUS_O,
    output logic                          GATE_EVENT_FLAG_O,
    output logic                          GATE_EVENT_IRQ_O,
    output logic                          OVERFLOW_FLAG_O,
    output logic                          OVERFLOW_IRQ_O,
    output logic                          WAKE_O,
    output logic                          VECTOR_TAKE_O,
    output logic [gcg_pkg::CNT_W-1:0]     VECTOR_ADDR_O,
    output logic                          WDT_OSC_ENABLE_O,
    output logic                          WDT_RESET_O
);
    import gcg_pkg::*;

    logic [T8_W-1:0]    t8_r;
    logic               t8_ovf_r;
    logic [T8_W-1:0]    pm_r;
    logic               pm_rst_r;
    logic [PRESC_W-1:0] presc_r;
    logic [PRESC_W-1:0] presc_mask;
    logic               presc_tick;
    logic [WDT_W-1:0]   wdt_r;
    logic               wdt_ovf_r;
    logic               src;
    logic               pol_src;
    logic               pol_prev_r;
    logic               tog_r;
    logic               tg;
    logic               tg_prev_r;
    logic               tg_rise;
    logic               tg_fall;
    gcg_sp_e            sp_r;
    gcg_sp_e            sp_nxt;
    logic               gate_val;
    logic               gate_val_r;
    logic               ext_prev_r;
    logic               tick;
    logic               sleep_ok;
    logic               inc;
    logic               ovf;
    logic [CNT_W-1:0]   cnt_r;
    logic               eq_prev_r;

    // eight-bit overflow timer, rising pulse on FFh to 00h
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            t8_r     <= T8_ZERO;
            t8_ovf_r <= 1'b0;
        end else begin
            t8_ovf_r <= T8_TICK_I && (t8_r == T8_MAX);
            if (T8_TICK_I) begin
                t8_r <= t8_r + 1'b1;
            end
        end
    end

    // period-match timer, reset after match pulses the gate
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            pm_r     <= T8_ZERO;
            pm_rst_r <= 1'b0;
        end else begin
            pm_rst_r <= PM_TICK_I && (pm_r == PERIOD_MATCH_VALUE_I);
            if (PM_TICK_I) begin
                pm_r <= (pm_r == PERIOD_MATCH_VALUE_I) ? T8_ZERO : pm_r + 1'b1;
            end
        end
    end

    // watchdog runs for the fuse or for gate use; only the fuse resets
    assign WDT_OSC_ENABLE_O = WATCHDOG_FUSE_ENABLE_I ||
                              (GATE_COUNT_ENABLE_I && GATE_SOURCE_SELECT_I == GSS_WDT);
    assign WDT_RESET_O      = wdt_ovf_r && WATCHDOG_FUSE_ENABLE_I;

    // prescaler division 2^rate when assigned, else 1:1
    assign presc_mask = PRESCALER_ASSIGN_I ? ~(PRESC_ONES << PRESCALER_RATE_I) : PRESC_ZERO;
    assign presc_tick = WDT_TICK_I && ((presc_r & presc_mask) == presc_mask);

    // watchdog prescaler and counter; clear restarts the interval
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            presc_r   <= PRESC_ZERO;
            wdt_r     <= '0;
            wdt_ovf_r <= 1'b0;
        end else if (!WDT_OSC_ENABLE_O || WATCHDOG_CLEAR_I || SLEEP_I && !WATCHDOG_FUSE_ENABLE_I) begin
            presc_r   <= PRESC_ZERO;
            wdt_r     <= '0;
            wdt_ovf_r <= 1'b0;
        end else begin
            wdt_ovf_r <= presc_tick && (&wdt_r);
            if (WDT_TICK_I) begin
                presc_r <= presc_r + 1'b1;
            end
            if (presc_tick) begin
                wdt_r <= wdt_r + 1'b1;
            end
        end
    end

    // gate source mux and polarity
    always_comb begin
        unique case (GATE_SOURCE_SELECT_I)
            GSS_PIN: src = GATE_INPUT_PIN_I;
            GSS_T8:  src = t8_ovf_r;
            GSS_PM:  src = pm_rst_r;
            GSS_WDT: src = wdt_ovf_r;
        endcase
    end
    assign pol_src = GATE_POLARITY_I ? src : !src;

    // toggle flip-flop, held clear when toggle or run is off
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            tog_r      <= 1'b0;
            pol_prev_r <= 1'b0;
        end else begin
            pol_prev_r <= pol_src;
            if (!GATE_TOGGLE_ENABLE_I || !COUNTER_RUN_I) begin
                tog_r <= 1'b0;
            end else if (pol_src && !pol_prev_r) begin
                tog_r <= !tog_r;
            end
        end
    end
    assign tg      = GATE_TOGGLE_ENABLE_I ? tog_r : pol_src;
    assign tg_rise = tg && !tg_prev_r;
    assign tg_fall = !tg && tg_prev_r;

    // single pulse sequencing; go is armed or active
    always_comb begin
        sp_nxt = sp_r;
        unique case (sp_r)
            SP_IDLE:   if (GATE_ACQUIRE_GO_SET_I) sp_nxt = SP_ARMED;
            SP_ARMED:  if (tg_rise) sp_nxt = SP_ACTIVE;
            SP_ACTIVE: if (tg_fall) sp_nxt = SP_IDLE;
            default:   sp_nxt = SP_IDLE;
        endcase
        if (!GATE_SINGLE_PULSE_ENABLE_I) begin
            sp_nxt = SP_IDLE;
        end
    end
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            sp_r      <= SP_IDLE;
            tg_prev_r <= 1'b0;
        end else begin
            sp_r      <= sp_nxt;
            tg_prev_r <= tg;
        end
    end
    assign GATE_ACQUIRE_GO_O = sp_r != SP_IDLE;

    // processed gate: with toggle on, one active window is one full cycle
    assign gate_val = GATE_SINGLE_PULSE_ENABLE_I ?
                      ((sp_r == SP_ARMED && tg_rise) || (sp_r == SP_ACTIVE && tg)) : tg;

    // gate status and gate event flag; set wins over clear
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            gate_val_r        <= 1'b0;
            GATE_EVENT_FLAG_O <= 1'b0;
        end else begin
            gate_val_r <= gate_val;
            if (gate_val_r && !gate_val) begin
                GATE_EVENT_FLAG_O <= 1'b1;
            end else if (GATE_EVENT_FLAG_CLR_I) begin
                GATE_EVENT_FLAG_O <= 1'b0;
            end
        end
    end
    assign GATE_LEVEL_STATUS_O = gate_val_r;
    assign GATE_EVENT_IRQ_O    = GATE_EVENT_FLAG_O && GATE_EVENT_IRQ_ENABLE_I;

    // counter clock selection and enables
    always_comb begin
        unique case (CLOCK_SOURCE_SELECT_I)
            CS_INSTR: tick = INSTR_TICK_I;
            CS_SYS:   tick = 1'b1;
            CS_EXT:   tick = EXT_CLK_I && !ext_prev_r;
            default:  tick = 1'b0; // reserved source never counts
        endcase
    end
    assign sleep_ok = !SLEEP_I || (CLOCK_SOURCE_SELECT_I == CS_EXT && SYNC_BYPASS_I);
    assign inc      = tick && sleep_ok && COUNTER_RUN_I &&
                      (!GATE_COUNT_ENABLE_I || gate_val);
    assign ovf      = inc && cnt_r == CNT_MAX && !CNT_WR_I && !SPECIAL_CLEAR_I;

    // counter pair; write beats special clear, clear beats increment
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            cnt_r      <= CNT_ZERO;
            ext_prev_r <= 1'b0;
        end else begin
            ext_prev_r <= EXT_CLK_I;
            if (CNT_WR_I) begin
                cnt_r <= CNT_WR_DATA_I;
            end else if (SPECIAL_CLEAR_I) begin
                cnt_r <= CNT_ZERO;
            end else if (inc) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
    assign COUNTER_PAIR_O = cnt_r;

    // overflow flag, wake and vector
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            OVERFLOW_FLAG_O <= 1'b0;
            WAKE_O          <= 1'b0;
            VECTOR_TAKE_O   <= 1'b0;
            VECTOR_ADDR_O   <= CNT_ZERO;
        end else begin
            if (ovf) begin
                OVERFLOW_FLAG_O <= 1'b1;
            end else if (OVERFLOW_FLAG_CLR_I) begin
                OVERFLOW_FLAG_O <= 1'b0;
            end
            WAKE_O        <= ovf && SLEEP_I && OVERFLOW_IRQ_ENABLE_I &&
                             PERIPHERAL_IRQ_ENABLE_I;
            VECTOR_TAKE_O <= ovf && SLEEP_I && OVERFLOW_IRQ_ENABLE_I &&
                             PERIPHERAL_IRQ_ENABLE_I && GLOBAL_IRQ_ENABLE_I;
            VECTOR_ADDR_O <= IRQ_VECTOR;
        end
    end
    assign OVERFLOW_IRQ_O = OVERFLOW_FLAG_O && COUNTER_RUN_I && OVERFLOW_IRQ_ENABLE_I &&
                            PERIPHERAL_IRQ_ENABLE_I && GLOBAL_IRQ_ENABLE_I;

    // capture copy and compare match pulse
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            CAPTURE_PAIR_O  <= CNT_ZERO;
            COMPARE_MATCH_O <= 1'b0;
            eq_prev_r       <= 1'b0;
        end else begin
            eq_prev_r       <= cnt_r == COMPARE_VALUE_I;
            COMPARE_MATCH_O <= (cnt_r == COMPARE_VALUE_I) && !eq_prev_r;
            if (CAPTURE_I) begin
                CAPTURE_PAIR_O <= cnt_r;
            end
        end
    end

    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);

    sequence sp_open_s;
        sp_r == SP_ACTIVE && GATE_SINGLE_PULSE_ENABLE_I;
    endsequence
    sequence sp_trail_s;
        tg_fall;
    endsequence

    src_route_a: assert property (GATE_SOURCE_SELECT_I == GSS_PIN && GATE_POLARITY_I && !GATE_TOGGLE_ENABLE_I && !GATE_SINGLE_PULSE_ENABLE_I |=> GATE_LEVEL_STATUS_O == $past(GATE_INPUT_PIN_I)) else $error("pin gate not routed");
    t8_wrap_a: assert property (T8_TICK_I && t8_r == T8_MAX |=> t8_ovf_r && t8_r == T8_ZERO) else $error("eight-bit wrap pulse missing");
    pm_reset_a: assert property (PM_TICK_I && pm_r == PERIOD_MATCH_VALUE_I |=> pm_rst_r && pm_r == T8_ZERO) else $error("period reset pulse missing");
    wdt_on_a: assert property (GATE_COUNT_ENABLE_I && GATE_SOURCE_SELECT_I == GSS_WDT |-> WDT_OSC_ENABLE_O) else $error("watchdog not powered");
    wdt_reset_a: assert property (!WATCHDOG_FUSE_ENABLE_I |-> !WDT_RESET_O) else $error("reset without fuse");
    tog_clear_a: assert property (!GATE_TOGGLE_ENABLE_I |=> !tog_r) else $error("toggle not held clear");
    tog_flip_a: assert property (GATE_TOGGLE_ENABLE_I && COUNTER_RUN_I && pol_src && !pol_prev_r |=> tog_r != $past(tog_r)) else $error("toggle missed edge");
    sp_done_a: assert property (sp_open_s ##0 sp_trail_s |=> !GATE_ACQUIRE_GO_O ##1 (!GATE_ACQUIRE_GO_O || $past(GATE_ACQUIRE_GO_SET_I))) else $error("go not cleared");
    sp_off_a: assert property (!GATE_SINGLE_PULSE_ENABLE_I |=> !GATE_ACQUIRE_GO_O) else $error("go survives disable");
    gate_flag_a: assert property (GATE_LEVEL_STATUS_O ##1 !GATE_LEVEL_STATUS_O |=> GATE_EVENT_FLAG_O) else $error("gate flag not set");
    wrap_a: assert property (ovf |=> cnt_r == CNT_ZERO && OVERFLOW_FLAG_O) else $error("wrap wrong");
    special_a: assert property (SPECIAL_CLEAR_I && !CNT_WR_I && !OVERFLOW_FLAG_O |=> cnt_r == CNT_ZERO && !OVERFLOW_FLAG_O) else $error("special clear wrong");
    wr_wins_a: assert property (CNT_WR_I |=> cnt_r == $past(CNT_WR_DATA_I)) else $error("write lost");
    gate_hold_a: assert property (COUNTER_RUN_I && GATE_COUNT_ENABLE_I && !gate_val && !CNT_WR_I && !SPECIAL_CLEAR_I |=> $stable(cnt_r)) else $error("count while gated off");
    sleep_hold_a: assert property (SLEEP_I && !SYNC_BYPASS_I && !CNT_WR_I && !SPECIAL_CLEAR_I |=> $stable(cnt_r)) else $error("count in sleep");
    capture_a: assert property (CAPTURE_I |=> CAPTURE_PAIR_O == $past(cnt_r)) else $error("capture wrong");
endmodule

// ===== rtl/gcg_pkg.sv
// gate and event logic constants for the 16-bit gated counter
package gcg_pkg;
    localparam int          CNT_W      = 16;
    localparam int          T8_W       = 8;
    localparam int          PRESC_W    = 7;
    localparam int          RATE_W     = 3;
    localparam logic [1:0]  GSS_PIN    = 2'h0;
    localparam logic [1:0]  GSS_T8     = 2'h1;
    localparam logic [1:0]  GSS_PM     = 2'h2;
    localparam logic [1:0]  GSS_WDT    = 2'h3;
    localparam logic [1:0]  CS_INSTR   = 2'h0;
    localparam logic [1:0]  CS_SYS     = 2'h1;
    localparam logic [1:0]  CS_EXT     = 2'h2;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO   = 16'h0000;
    localparam logic [7:0]  T8_MAX     = 8'hFF;
    localparam logic [7:0]  T8_ZERO    = 8'h00;
    localparam logic [6:0]  PRESC_ONES = 7'h7F;
    localparam logic [6:0]  PRESC_ZERO = 7'h00;
    localparam logic [15:0] IRQ_VECTOR = 16'h0004;
    typedef enum logic [2:0] {
        SP_IDLE   = 3'h1,
        SP_ARMED  = 3'h2,
        SP_ACTIVE = 3'h4
    } gcg_sp_e;
endpackage

// ===== tb/gcg_partner.sv
// partner model: gate pin, sibling timer pulses and external clock
`timescale 1ns/100ps
module gcg_partner (
    input  wire logic clk_i,
    output logic      pin_o,
    output logic      t8_o,
    output logic      pm_o,
    output logic      wdt_o,
    output logic      ext_o
);
    // every line idles low from time zero
    initial begin
        {pin_o, t8_o, pm_o, wdt_o, ext_o} = 5'h00;
    end
    // gate pin level changes just after a rising edge
    task automatic set_pin(input logic v);
        @(posedge clk_i);
        #5;
        pin_o = v;
    endtask
    // n one-cycle ticks with a gap: 0 eight-bit, 1 period, 2 watchdog, 3 ext clock
    task automatic tick(input int sel, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            #5;
            t8_o = (sel == 0);
            pm_o = (sel == 1);
            wdt_o = (sel == 2);
            ext_o = (sel == 3);
            @(posedge clk_i);
            #5;
            {t8_o, pm_o, wdt_o, ext_o} = 4'h0;
        end
    endtask
endmodule

// ===== tb/gated_counter_gate_logic_tb_top.sv
// self-checking bench for the gated counter gate logic
`timescale 1ns/100ps
module gated_counter_gate_logic_tb_top;
    import gcg_pkg::*;
    logic clk, rst_n, pin, t8, pm, wdt, ext, wrst_seen, itk;
    logic run, gen, pol, tog, spm, gos, global_irq_enable, gclr, oie, oclr, pie, glb, sby, slp, fuse, wclr, prescaler_assign, cwr, sclr, cap;
    logic [1:0] sel, cs;
    logic [RATE_W-1:0] rate;
    logic [T8_W-1:0] per;
    logic [CNT_W-1:0] wd, cmpv, cnt, capp, vad;
    logic mt, go, gst, gfl, girq, ofl, oirq, wake, vt, wosc, wrst;
    int failures = 0;
    int total_checks = 0;

    gcg_partner u_prt (.clk_i(clk), .pin_o(pin), .t8_o(t8), .pm_o(pm), .wdt_o(wdt), .ext_o(ext));
    gcg_gate_logic #(.WDT_W(2)) u_dut (
        .CORE_CLK_I(clk), .RESETN_I(rst_n), .GATE_INPUT_PIN_I(pin), .GATE_SOURCE_SELECT_I(sel),
        .GATE_POLARITY_I(pol), .GATE_COUNT_ENABLE_I(gen), .COUNTER_RUN_I(run), .GATE_TOGGLE_ENABLE_I(tog),
        .GATE_SINGLE_PULSE_ENABLE_I(spm), .GATE_ACQUIRE_GO_SET_I(gos), .GATE_EVENT_IRQ_ENABLE_I(global_irq_enable),
        .GATE_EVENT_FLAG_CLR_I(gclr), .OVERFLOW_IRQ_ENABLE_I(oie), .OVERFLOW_FLAG_CLR_I(oclr),
        .PERIPHERAL_IRQ_ENABLE_I(pie), .GLOBAL_IRQ_ENABLE_I(glb), .CLOCK_SOURCE_SELECT_I(cs),
        .SYNC_BYPASS_I(sby), .INSTR_TICK_I(itk), .EXT_CLK_I(ext), .SLEEP_I(slp), .T8_TICK_I(t8),
        .PM_TICK_I(pm), .PERIOD_MATCH_VALUE_I(per), .WATCHDOG_FUSE_ENABLE_I(fuse), .WDT_TICK_I(wdt),
        .WATCHDOG_CLEAR_I(wclr), .PRESCALER_ASSIGN_I(prescaler_assign), .PRESCALER_RATE_I(rate), .CNT_WR_I(cwr),
        .CNT_WR_DATA_I(wd), .SPECIAL_CLEAR_I(sclr), .CAPTURE_I(cap), .COMPARE_VALUE_I(cmpv),
        .COUNTER_PAIR_O(cnt), .CAPTURE_PAIR_O(capp), .COMPARE_MATCH_O(mt), .GATE_ACQUIRE_GO_O(go),
        .GATE_LEVEL_STATUS_O(gst), .GATE_EVENT_FLAG_O(gfl), .GATE_EVENT_IRQ_O(girq), .OVERFLOW_FLAG_O(ofl),
        .OVERFLOW_IRQ_O(oirq), .WAKE_O(wake), .VECTOR_TAKE_O(vt), .VECTOR_ADDR_O(vad),
        .WDT_OSC_ENABLE_O(wosc), .WDT_RESET_O(wrst));

    // free-running clock, 50 ns period
    always #25 clk = ~clk;
    // remembers any watchdog reset pulse
    always @(posedge clk) if (wrst === 1'h1) wrst_seen <= 1'h1;

    // step n edges, landing just after the last one
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    // one-cycle pulse on a strobe input
    task automatic pulse(ref logic s);
        s = 1'h1;
        cyc(1);
        s = 1'h0;
    endtask
    // counter write strobe
    task automatic wr(input logic [CNT_W-1:0] v);
        wd = v;
        pulse(cwr);
    endtask
    // bounded wait for wake (1) or compare match (0)
    task automatic wait_hi(input int w);
        for (int i = 0; i < 8 && (w ? wake : mt) !== 1'h1; i++) cyc(1);
    endtask
    // compare one-bit result
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
        end
    endtask
    // compare sixteen-bit result
    task automatic chk16(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // eight-bit overflow and period reset through the toggle stage
    task automatic t_sources;
        sel = GSS_T8;
        cyc(1);
        tog = 1'h1;
        u_prt.tick(0, 255);
        cyc(3);
        chk1(gst, 1'h0);
        u_prt.tick(0, 1);
        cyc(3);
        chk1(gst, 1'h1);
        tog = 1'h0;
        cyc(3);
        chk1(gst, 1'h0);
        sel = GSS_PM;
        per = 8'h03;
        cyc(1);
        tog = 1'h1;
        u_prt.tick(1, 3);
        cyc(3);
        chk1(gst, 1'h0);
        u_prt.tick(1, 1);
        cyc(3);
        chk1(gst, 1'h1);
        tog = 1'h0;
    endtask
    // watchdog as gate source: power, interval and reset isolation
    task automatic t_wdt;
        run = 1'h0;
        gen = 1'h1;
        sel = GSS_WDT;
        cyc(1);
        chk1(wosc, 1'h1);
        run = 1'h1;
        tog = 1'h1;
        pulse(wclr);
        u_prt.tick(2, 3);
        cyc(3);
        chk1(gst, 1'h0);
        u_prt.tick(2, 1);
        cyc(3);
        chk1(gst, 1'h1);
        prescaler_assign = 1'h1;
        rate = 3'h1;
        pulse(wclr);
        u_prt.tick(2, 7);
        cyc(3);
        chk1(gst, 1'h1);
        u_prt.tick(2, 1);
        cyc(3);
        chk1(gst, 1'h0);
        chk1(wrst_seen, 1'h0);
        {tog, gen, prescaler_assign} = 3'h0;
        cyc(1);
        chk1(wosc, 1'h0);
    endtask
    // pin gate polarity, level status and gate event flag
    task automatic t_pin;
        sel = GSS_PIN;
        gen = 1'h1;
        u_prt.set_pin(1'h0);
        wr(16'h0000);
        cyc(5);
        chk16(cnt, 16'h0000);
        u_prt.set_pin(1'h1);
        cyc(10);
        u_prt.set_pin(1'h0);
        cyc(3);
        chk1(cnt >= 16'h0009 && cnt <= 16'h000C, 1'h1);
        pol = 1'h0;
        wr(16'h0000);
        cyc(5);
        chk1(cnt >= 16'h0004, 1'h1);
        pol = 1'h1;
        gen = 1'h0;
        cyc(3);
        pulse(gclr);
        u_prt.set_pin(1'h1);
        cyc(3);
        chk1(gst, 1'h1);
        u_prt.set_pin(1'h0);
        cyc(3);
        chk1(gfl, 1'h1);
        chk1(girq, 1'h0);
        global_irq_enable = 1'h1;
        #1;
        chk1(girq, 1'h1);
        pulse(gclr);
        chk1(gfl, 1'h0);
        global_irq_enable = 1'h0;
    endtask
    // rollover, flag and interrupt enables
    task automatic t_overflow;
        run = 1'h0;
        pulse(oclr);
        wr(16'hFFFD);
        {oie, pie, glb} = 3'h7;
        run = 1'h1;
        for (int i = 0; i < 8 && cnt !== 16'h0000; i++) cyc(1);
        chk16(cnt, 16'h0000);
        chk1(ofl, 1'h1);
        chk1(oirq, 1'h1);
        run = 1'h0;
        #1;
        chk1(oirq, 1'h0);
        pulse(oclr);
        chk1(ofl, 1'h0);
        {oie, pie, glb} = 3'h0;
    endtask
    // special clear, write priority, capture and compare
    task automatic t_ccp;
        wd = 16'h1234;
        {cwr, sclr} = 2'h3;
        cyc(1);
        {cwr, sclr} = 2'h0;
        chk16(cnt, 16'h1234);
        pulse(sclr);
        chk16(cnt, 16'h0000);
        chk1(ofl, 1'h0);
        wr(16'h00AB);
        pulse(cap);
        cyc(1);
        chk16(capp, 16'h00AB);
        cmpv = 16'h0055;
        wr(16'h0055);
        wait_hi(0);
        chk1(mt, 1'h1);
    endtask
    // single-pulse acquisition and its cancel
    task automatic t_single;
        logic [CNT_W-1:0] hold;
        {gen, run} = 2'h3;
        wr(16'h0000);
        spm = 1'h1;
        cyc(1);
        pulse(gos);
        cyc(1);
        chk1(go, 1'h1);
        u_prt.set_pin(1'h1);
        cyc(6);
        u_prt.set_pin(1'h0);
        cyc(3);
        chk1(go, 1'h0);
        chk1(cnt >= 16'h0005 && cnt <= 16'h0008, 1'h1);
        hold = cnt;
        u_prt.set_pin(1'h1);
        cyc(6);
        u_prt.set_pin(1'h0);
        cyc(3);
        chk16(cnt, hold);
        pulse(gos);
        cyc(1);
        spm = 1'h0;
        cyc(2);
        chk1(go, 1'h0);
    endtask
    // sleep: held on system clock, asynchronous external wrap wakes
    task automatic t_sleep;
        gen = 1'h0;
        slp = 1'h1;
        wr(16'h0100);
        cyc(5);
        chk16(cnt, 16'h0100);
        cs = CS_EXT;
        sby = 1'h1;
        pulse(oclr);
        wr(16'hFFFF);
        {oie, pie, glb} = 3'h7;
        fork
            u_prt.tick(3, 1);
            wait_hi(1);
        join
        chk1(wake, 1'h1);
        chk1(vt, 1'h1);
        chk16(vad, IRQ_VECTOR);
        slp = 1'h0;
    endtask
    // fuse-enabled watchdog resets on its own; instruction ticks drive the count
    task automatic t_fuse_instr;
        {gen, prescaler_assign} = 2'h0;
        fuse = 1'h1;
        cyc(1);
        chk1(wosc, 1'h1);
        u_prt.tick(2, 4);
        cyc(3);
        chk1(wrst_seen, 1'h1);
        fuse = 1'h0;
        cs = CS_INSTR;
        run = 1'h1;
        wr(16'h0000);
        itk = 1'h1;
        cyc(3);
        itk = 1'h0;
        cyc(2);
        chk16(cnt, 16'h0003);
    endtask

    // reset, then each scenario in turn
    initial begin
        clk = 1'h0;
        rst_n = 1'h0;
        wrst_seen = 1'h0;
        itk = 1'h0;
        {run, gen, pol, tog, spm, gos, global_irq_enable, gclr, oie, oclr, pie, glb, sby, slp, fuse, wclr, prescaler_assign, cwr, sclr, cap} = '0;
        {sel, cs, rate, per, wd, cmpv} = '0;
        repeat (16) @(posedge clk);
        #5;
        rst_n = 1'h1;
        {cs, run, pol} = {CS_SYS, 2'h3};
        t_sources();
        t_wdt();
        t_pin();
        t_overflow();
        t_ccp();
        t_single();
        t_sleep();
        t_fuse_instr();
        report_and_stop();
    end
    // hang guard, well beyond the expected run length
    initial begin
        #500000;
        failures++;
        report_and_stop();
    end
endmodule
